// File: hw/stev_cfg.svh
`ifndef STEV_CFG_SVH
`define STEV_CFG_SVH

// Register offsets on the local register port
`define STEV_ADDR_W      8
`define STEV_ADDR_PORT   8'h04
`define STEV_ADDR_EVT    8'h30

// Pin port layout
`define STEV_NPIN        16
`define STEV_BYTE_W      8
`define STEV_BYTE_STRIDE 16
`define STEV_DIR_BIT     8
`define STEV_PIN_RST     8'h00
`define STEV_RSVD_PAD    7'h00

// Event register layout
`define STEV_NEVT        15
`define STEV_RESP_OFS    16
`define STEV_EVT_RST     15'h0000
`define STEV_EVT_CAL     0
`define STEV_EVT_PIN0    8

`endif

// File: hw/stev_pkg.sv
package stev_pkg;

  // Levels of the surrounding acquisition logic, sampled on CLK
  typedef struct packed {
    logic in_thr;        // Input buffer threshold flag
    logic in_ovf;        // Input overflow or underflow
    logic in_burst_busy; // Input burst in progress
    logic in_clk;        // Input sample clock
    logic out_clk;       // Output clock
    logic out_thr;       // Output buffer threshold flag
    logic load_rdy;      // Output load-ready flag
    logic out_burst_rdy; // Output burst ready
    logic out_ovf;       // Output buffer or frame overflow
  } stev_ext_evt_t;

  // Calibration request state
  typedef enum logic {
    STEV_CAL_IDLE = 1'b0,
    STEV_CAL_RUN  = 1'b1
  } stev_cal_state_t;

endpackage

// File: hw/stev_sync.sv
`timescale 1ns/100ps
`include "stev_cfg.svh"

module stev_sync (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  input  wire logic                    CE,
  // Levels in and out
  input  wire logic [`STEV_NPIN-1:0]   D,
  output logic      [`STEV_NPIN-1:0]   Q
);

  logic [`STEV_NPIN-1:0] meta_reg;

  // Two stages; only the second stage reads the first
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_reg <= '0;
      Q        <= '0;
    end else if (CE) begin
      meta_reg <= D;
      Q        <= meta_reg;
    end
  end

endmodule

// File: hw/stev_top.sv
// Functional notes
// RULE1: Sixteen pins as two independent bytes
// RULE2: Pin levels read and drive unchanged
// RULE3: Per-byte direction bit, one drives pins
// RULE4: Both bytes inputs after reset
// RULE5: Reserved port bits read as zero
// RULE6: Calibration request bit self-clears when finished
// RULE7: Software waits for event or timeout
// RULE8: Engine calibrates inputs all, outputs selected
// RULE9: Correction values kept in volatile storage
// RULE10: Calibration-good high after init, cleared on fail
// RULE11: Response bit sixteen above its selection
// RULE12: Rising edge sets response, sticky afterwards
// RULE13: Zero to response or selection clears
// RULE14: Writing one to response does nothing
// RULE15: Selection bits 0-7 map input events; the code puts calibration done at bit 0 and the output clock at bit 7
// RULE16: Selection bits 8-14 map output events; the code puts the pin zero level at bit 8
// RULE17: Calibration done pulses when request clears
// RULE18: Pin inputs pass two flip-flops first
`timescale 1ns/100ps
`include "stev_cfg.svh"

module stev_top (
  // Clock, reset and enable
  input  wire logic                      CLK,
  input  wire logic                      RST_B,
  input  wire logic                      CE,
  // Register port
  input  wire logic [`STEV_ADDR_W-1:0]   REG_ADDR,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [31:0]               REG_WDATA,
  output logic      [31:0]               REG_RDATA,
  output logic                           REG_ACK,
  // Connector pins
  input  wire logic [`STEV_NPIN-1:0]     PIN_I,
  output logic      [`STEV_NPIN-1:0]     PIN_O,
  output logic      [`STEV_NPIN-1:0]     PIN_OE,
  // Calibration control and engine handshake
  input  wire logic                      CAL_REQ,
  input  wire logic                      CAL_DONE,
  input  wire logic                      CAL_FAIL,
  output logic                           CAL_START,
  output logic                           CAL_BUSY,
  output logic                           CAL_GOOD,
  // Event sources
  input  wire stev_pkg::stev_ext_evt_t   EXT_EVT
);
  import stev_pkg::*;

  // Address match, shared by both register decodes
  function automatic logic stev_hit(input logic [`STEV_ADDR_W-1:0] a,
                                    input logic [`STEV_ADDR_W-1:0] ofs);
    stev_hit = (a == ofs);
  endfunction

  wire wr_port = CE && REG_WR && stev_hit(REG_ADDR, `STEV_ADDR_PORT);
  wire rd_port = stev_hit(REG_ADDR, `STEV_ADDR_PORT);
  wire wr_evt  = CE && REG_WR && stev_hit(REG_ADDR, `STEV_ADDR_EVT);
  wire rd_evt  = stev_hit(REG_ADDR, `STEV_ADDR_EVT);

  // Pins resynchronised before any use
  logic [`STEV_NPIN-1:0] pin_sync;

  stev_sync u_sync (
    .CLK   (CLK),
    .RST_B (RST_B),
    .CE    (CE),
    .D     (PIN_I),
    .Q     (pin_sync)
  ); // RULE18

  // Per-byte data latch and direction; reads see pins when input
  logic [`STEV_BYTE_W-1:0] byte_view [2];
  logic [1:0]              dir_view;

  for (genvar b = 0; b < 2; b++) begin : g_byte
    logic [`STEV_BYTE_W-1:0] dout_reg;
    logic                    dir_reg;
    logic [`STEV_BYTE_W-1:0] oe_reg;

    // Data bytes reset to zero although software may not rely on it
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        dout_reg <= `STEV_PIN_RST;
        dir_reg  <= 1'b0; // RULE4
        oe_reg   <= '0;
      end else if (wr_port) begin
        dout_reg <= REG_WDATA[b*`STEV_BYTE_STRIDE +: `STEV_BYTE_W]; // RULE1
        dir_reg  <= REG_WDATA[b*`STEV_BYTE_STRIDE + `STEV_DIR_BIT]; // RULE3
        oe_reg   <= {`STEV_BYTE_W{REG_WDATA[b*`STEV_BYTE_STRIDE
                                            + `STEV_DIR_BIT]}};
      end
    end

    // Read side: latch when driving, synchronised pins otherwise
    assign byte_view[b] = dir_reg ? dout_reg
                        : pin_sync[b*`STEV_BYTE_W +: `STEV_BYTE_W]; // RULE2
    assign dir_view[b]  = dir_reg;
    assign PIN_O[b*`STEV_BYTE_W +: `STEV_BYTE_W]  = dout_reg;  // RULE2
    assign PIN_OE[b*`STEV_BYTE_W +: `STEV_BYTE_W] = oe_reg;    // RULE3
  end

  wire [31:0] port_word = {`STEV_RSVD_PAD, dir_view[1], byte_view[1],
                           `STEV_RSVD_PAD, dir_view[0], byte_view[0]}; // RULE5

  // Calibration request: stays set until the engine reports completion
  stev_cal_state_t cal_state_reg;
  stev_cal_state_t cal_state_next;
  logic            good_reg;
  logic            start_reg;
  logic            cal_evt_reg;

  wire cal_end = (cal_state_reg == STEV_CAL_RUN) && CAL_DONE && !CAL_REQ;

  // A new request while running restarts the engine, so requests are
  // never refused; the engine keeps corrections in volatile storage
  always_comb begin
    cal_state_next = cal_state_reg;
    unique case (cal_state_reg)
      STEV_CAL_IDLE: begin
        if (CAL_REQ) begin
          cal_state_next = STEV_CAL_RUN;
        end
      end
      STEV_CAL_RUN: begin
        if (cal_end) begin
          cal_state_next = STEV_CAL_IDLE; // RULE6
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cal_state_reg <= STEV_CAL_IDLE;
      good_reg      <= 1'b1; // RULE10
      start_reg     <= 1'b0;
      cal_evt_reg   <= 1'b0;
    end else if (CE) begin
      cal_state_reg <= cal_state_next;
      start_reg     <= CAL_REQ; // RULE8 RULE9
      cal_evt_reg   <= cal_end; // RULE17
      if (cal_end) begin
        good_reg <= !CAL_FAIL; // RULE10
      end
    end
  end

  assign CAL_BUSY  = (cal_state_reg == STEV_CAL_RUN);
  assign CAL_START = start_reg;
  assign CAL_GOOD  = good_reg;

  // Event levels; falling-edge events are fed inverted so one rising
  // detector serves every source
  logic [`STEV_NEVT-1:0] ev_lvl;
  assign ev_lvl = {EXT_EVT.out_ovf, EXT_EVT.out_burst_rdy,
                   EXT_EVT.load_rdy, !EXT_EVT.load_rdy,
                   EXT_EVT.out_thr, !EXT_EVT.out_thr,
                   pin_sync[0],
                   EXT_EVT.out_clk, EXT_EVT.in_clk,
                   !EXT_EVT.in_burst_busy, EXT_EVT.in_burst_busy,
                   EXT_EVT.in_ovf, EXT_EVT.in_thr, !EXT_EVT.in_thr,
                   cal_evt_reg}; // RULE15 RULE16

  logic [`STEV_NEVT-1:0] ev_prev_reg;
  logic [`STEV_NEVT-1:0] sel_reg;
  logic [`STEV_NEVT-1:0] resp_reg;
  logic [`STEV_NEVT-1:0] sel_next;
  logic [`STEV_NEVT-1:0] resp_next;
  logic [`STEV_NEVT-1:0] ev_rise;
  logic [`STEV_NEVT-1:0] resp_clr;

  assign ev_rise  = ev_lvl & ~ev_prev_reg; // RULE12
  // Zero in the response bit or its selection bit clears; ones ignored
  assign resp_clr = wr_evt
                  ? ~(REG_WDATA[`STEV_RESP_OFS +: `STEV_NEVT]
                      & REG_WDATA[`STEV_NEVT-1:0])
                  : '0; // RULE13 RULE14
  assign sel_next = wr_evt ? REG_WDATA[`STEV_NEVT-1:0] : sel_reg;
  // Set wins over a clear in the same cycle, so no event is lost
  assign resp_next = (resp_reg & ~resp_clr) | (ev_rise & sel_reg); // RULE11

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ev_prev_reg <= `STEV_EVT_RST;
      sel_reg     <= `STEV_EVT_RST;
      resp_reg    <= `STEV_EVT_RST;
    end else if (CE) begin
      ev_prev_reg <= ev_lvl;
      sel_reg     <= sel_next;
      resp_reg    <= resp_next; // RULE12
    end
  end

  wire [31:0] evt_word = {1'b0, resp_reg, 1'b0, sel_reg}; // RULE16

  // Read data is registered; unmapped addresses read zero
  wire [31:0] rd_mux = rd_port ? port_word
                     : rd_evt  ? evt_word
                     : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h0000_0000;
      REG_ACK   <= 1'b0;
    end else if (CE) begin
      REG_ACK <= REG_RD || REG_WR;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_cal_end;
    CE && CAL_BUSY && CAL_DONE && !CAL_REQ;
  endsequence

  sequence s_cal_idle_pulse;
    !CAL_BUSY && cal_evt_reg;
  endsequence

  a_oe_follows_dir: assert property ( // RULE3
    wr_port |=> (PIN_OE[0] == $past(REG_WDATA[8]))
            && (PIN_OE[8] == $past(REG_WDATA[24])))
    else $error("Pin enable does not follow direction bit");

  a_read_pins_in: assert property ( // RULE18
    CE && REG_RD && rd_port && !PIN_OE[0] && !wr_port
      |=> REG_RDATA[7:0] == $past(pin_sync[7:0]))
    else $error("Input byte read does not show synchronised pins");

  a_reserved_zero: assert property ( // RULE5
    CE && REG_RD && rd_port
      |=> REG_RDATA[15:9] == 7'h00 && REG_RDATA[31:25] == 7'h00)
    else $error("Reserved port bits not zero");

  a_resp_set_cause: assert property ( // RULE11
    CE |=> ((resp_reg & ~$past(resp_reg))
            & ~$past(ev_rise & sel_reg)) == '0)
    else $error("Response set without a selected rising event");

  a_resp_sticky: assert property ( // RULE12
    CE && !wr_evt |=> (resp_reg & $past(resp_reg)) == $past(resp_reg))
    else $error("Response bit dropped without a clear");

  a_resp_clear: assert property ( // RULE13
    wr_evt && !REG_WDATA[0] && !(ev_rise[0] && sel_reg[0])
      |=> !resp_reg[0])
    else $error("Clearing selection left response set");

  a_cal_end_pulse: assert property ( // RULE17
    s_cal_end |=> s_cal_idle_pulse ##1 (!cal_evt_reg || !$past(CE)))
    else $error("Calibration end not a single pulse");

  a_cal_fail_good: assert property ( // RULE10
    s_cal_end ##0 CAL_FAIL |=> !CAL_GOOD)
    else $error("Calibration-good not cleared after failure");

  a_cal_start: assert property ( // RULE6
    CE && CAL_REQ |=> CAL_BUSY && CAL_START)
    else $error("Request did not start calibration");

  a_sel_write: assert property ( // RULE11
    wr_evt
      |=> sel_reg == $past(REG_WDATA[`STEV_NEVT-1:0]))
    else $error("Selection field not taken from the write");

  a_resp_zero_clear: assert property ( // RULE13
    wr_evt && !REG_WDATA[`STEV_RESP_OFS + `STEV_EVT_CAL]
      && !(ev_rise[`STEV_EVT_CAL] && sel_reg[`STEV_EVT_CAL])
      |=> !resp_reg[`STEV_EVT_CAL])
    else $error("Zero written to response left it set");

  a_write_one_noop: assert property ( // RULE14
    wr_evt && ((ev_rise & sel_reg) == '0)
      |=> (resp_reg & ~$past(resp_reg)) == '0)
    else $error("Register write set a response bit");

  a_pin0_event: assert property ( // RULE16
    CE && ev_rise[`STEV_EVT_PIN0] && sel_reg[`STEV_EVT_PIN0]
      |=> resp_reg[`STEV_EVT_PIN0])
    else $error("Selected pin zero rise not recorded");

  a_out_byte_read: assert property ( // RULE2
    CE && REG_RD && rd_port && PIN_OE[`STEV_BYTE_W]
      |=> REG_RDATA[`STEV_BYTE_STRIDE +: `STEV_BYTE_W]
          == $past(PIN_O[`STEV_BYTE_W +: `STEV_BYTE_W]))
    else $error("Output byte read does not show driven value");

  a_ce_freeze: assert property ( // RULE3
    !CE |=> $stable(PIN_OE) && $stable(PIN_O) && $stable(CAL_BUSY))
    else $error("State moved while enable was low");

  a_good_holds: assert property ( // RULE10
    !(CE && CAL_BUSY && CAL_DONE && !CAL_REQ) |=> $stable(CAL_GOOD))
    else $error("Calibration-good changed outside a calibration end");

endmodule

// File: sim/stev_pin_model.sv
`timescale 1ns/100ps

// Equipment on the connector; it lets go of every pin the board drives
module stev_pin_model (
  // Board side
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe,
  // Equipment side
  input  wire logic [15:0] eq_val,
  output logic      [15:0] pin_i
);
  // Wire level per pin, so no contention can ever show up as X
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & eq_val);
endmodule

// File: sim/test_status_events_and_dio.sv
`timescale 1ns/100ps
`include "stev_cfg.svh"

module test_status_events_and_dio;
  import stev_pkg::*;
  logic          clk, rst_b, ce, reg_wr, reg_rd, reg_ack;
  logic          cal_req, cal_done, cal_fail, cal_start, cal_busy, cal_good;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, w, r;
  logic [15:0]   pin_o, pin_oe, pin_i, eq_val, p;
  logic [14:0]   sel, exp_resp;
  stev_ext_evt_t ext_evt, n;
  integer        seed = 32'hBC02;
  int            err_count = 0;
  int            n_compared = 0;

  // Block under test and the equipment behind its pins
  stev_top i_dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .CAL_REQ(cal_req), .CAL_DONE(cal_done),
    .CAL_FAIL(cal_fail), .CAL_START(cal_start), .CAL_BUSY(cal_busy),
    .CAL_GOOD(cal_good), .EXT_EVT(ext_evt));
  stev_pin_model i_pins (.pin_o(pin_o), .pin_oe(pin_oe), .eq_val(eq_val),
    .pin_i(pin_i));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare with four-state equality so an X matches only an expected X
  task check(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One-cycle strobe access; the ack must follow exactly one cycle later
  task reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check(32'(reg_ack), 32'h1);
    r = reg_rdata;
  endtask

  // Port word as it should read back: input bytes show the wire level
  function logic [31:0] exp_port(logic [31:0] v, logic [15:0] e);
    logic [7:0] lo, hi;
    lo = v[8] ? v[7:0] : e[7:0];
    hi = v[24] ? v[23:16] : e[15:8];
    return {7'h00, v[24], hi, 7'h00, v[8], lo};
  endfunction

  // Event edges from one level set to the next (struct is MSB first)
  function logic [14:0] edges(stev_ext_evt_t o, stev_ext_evt_t nw,
                              logic p0o, logic p0n);
    logic [8:0] rs, fl;
    rs = ~o & nw;
    fl = o & ~nw;
    return {rs[0], rs[1], rs[2], fl[2], rs[3], fl[3], ~p0o & p0n, rs[4],
            rs[5], fl[6], rs[6], rs[7], rs[8], fl[8], 1'b0};
  endfunction

  // Request, engine finish with given result, then status readback
  task run_cal(input logic fail);
    @(negedge clk);
    cal_req = 1'b1;
    @(negedge clk);
    cal_req = 1'b0;
    check(32'({cal_start, cal_busy}), 32'h3);
    @(negedge clk);
    check(32'({cal_start, cal_busy}), 32'h1);
    repeat (3) @(negedge clk);
    cal_done = 1'b1;
    cal_fail = fail;
    @(negedge clk);
    cal_done = 1'b0;
    cal_fail = 1'b0;
    check(32'({cal_busy, cal_good}), 32'({1'b0, ~fail}));
  endtask

  // Main sequence: reset values, pin port, events with calibration
  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, cal_req, cal_done, cal_fail} = 5'h00;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    ext_evt = stev_ext_evt_t'(9'h000);
    eq_val = 16'hA5C3;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check(32'(pin_oe), 32'h0);
    check(32'(cal_good), 32'h1);
    reg_acc(1'b0, `STEV_ADDR_PORT, 32'h0);
    check(r, exp_port(32'h0, eq_val));
    reg_acc(1'b0, `STEV_ADDR_EVT, 32'h0);
    check(r, 32'h0);
    reg_acc(1'b0, 8'h08, 32'h0);
    check(r, 32'h0);
    // Enable low: a write must be neither taken nor answered
    @(negedge clk);
    ce = 1'b0;
    reg_addr = `STEV_ADDR_PORT;
    reg_wdata = 32'hFFFF_FFFF;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    check(32'({reg_ack, pin_oe}), 32'h0);
    ce = 1'b1;
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      w = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0 : $random(seed);
      reg_acc(1'b1, `STEV_ADDR_PORT, w);
      eq_val = 16'($random(seed));
      repeat (3) @(negedge clk);
      check(32'(pin_oe), 32'({{8{w[24]}}, {8{w[8]}}}));
      check(32'(pin_o), 32'({w[23:16], w[7:0]}));
      reg_acc(1'b0, `STEV_ADDR_PORT, 32'h0);
      check(r, exp_port(w, eq_val));
    end
    $display("test port done");
    reg_acc(1'b1, `STEV_ADDR_PORT, 32'h0);
    // Let the pin zero level settle through the synchroniser before any
    // selection exists, so the turnaround cannot leave a stray rise
    repeat (4) @(negedge clk);
    exp_resp = 15'h0000;
    for (int k = 0; k < 40; k++) begin
      w = $random(seed);
      w[30:16] = w[30:16] | 15'($random(seed));
      w[15] = 1'b0;
      w[31] = 1'b0;
      reg_acc(1'b1, `STEV_ADDR_EVT, w);
      sel = w[14:0];
      exp_resp = exp_resp & w[30:16] & sel;
      n = stev_ext_evt_t'(9'($random(seed)));
      p = 16'($random(seed));
      @(negedge clk);
      exp_resp = exp_resp | (edges(ext_evt, n, eq_val[0], p[0]) & sel);
      ext_evt = n;
      eq_val = p;
      if (k % 4 == 3) begin
        run_cal(k % 8 == 3);
        exp_resp[0] = exp_resp[0] | sel[0];
      end
      repeat (4) @(negedge clk);
      reg_acc(1'b0, `STEV_ADDR_EVT, 32'h0);
      check(r, {1'b0, exp_resp, 1'b0, sel});
    end
    $display("test events done");
    print_verdict;
  end

  // Cut a hang short
  initial begin
    #400000;
    err_count++;
    print_verdict;
  end
endmodule
